// *** design/msi_defines.svh ***
// Register indices, field positions, vectors and reset values of the status and interrupt unit
`ifndef MSI_DEFINES_SVH
`define MSI_DEFINES_SVH

// Register indices; byte address is four times the index
`define MSI_IDX_STATUS 10'h00A
`define MSI_IDX_CTRL0 10'h00B
`define MSI_IDX_CTRL1 10'h01E

// Status register fields
`define MSI_ST_CARRY 0
`define MSI_ST_HALF 1
`define MSI_ST_ZERO 2
`define MSI_ST_WRAP 3
`define MSI_ST_PDOWN 4
`define MSI_ST_WDOG 5

// Primary control register fields
`define MSI_C0_GIE 0
`define MSI_C0_EXT_EN 1
`define MSI_C0_T0_EN 2
`define MSI_C0_T1_EN 3
`define MSI_C0_EXT_P 4
`define MSI_C0_T0_P 5
`define MSI_C0_T1_P 6

// Secondary control register fields
`define MSI_C1_CONV_EN 0
`define MSI_C1_CONV_P 4

// Entry vectors
`define MSI_VEC_EXT 12'h004
`define MSI_VEC_T0 12'h008
`define MSI_VEC_T1 12'h00C
`define MSI_VEC_CONV 12'h010

// Sizes and reset values
`define MSI_PC_W 12
`define MSI_STACK_DEPTH 6
`define MSI_REG_RST 8'h00
`define MSI_PIN_IDLE 1'b1

`endif

// *** design/msi_pkg.sv ***
// Types shared by the status and interrupt unit
package msi_pkg;

    typedef enum logic [2:0] {
        MSI_ALU_ADD,
        MSI_ALU_ADC,
        MSI_ALU_SUB,
        MSI_ALU_SBC,
        MSI_ALU_AND,
        MSI_ALU_OR,
        MSI_ALU_XOR,
        MSI_ALU_RLC
    } msi_alu_op_t;

    typedef enum logic {
        MSI_PWR_RUN,
        MSI_PWR_DOWN
    } msi_pwr_t;

endpackage

// *** design/msi_stack_mem.sv ***
// Return address memory with registered read data
`timescale 1ns/100ps
module msi_stack_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    // Clock
    input wire logic clk_sys,
    // Write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read side
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] rdata_r;

    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_param
            $error("msi_stack_mem: DEPTH must be 1 to 2**AW");
        end
    endgenerate

    // No reset on the array; entries are only read after being written
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
        rdata_r <= mem_r[raddr];
    end

    assign rdata = rdata_r;

endmodule

// *** design/msi_unit.sv ***
// Status flags, vectored interrupt control and return stack of the 8-bit core
//
// Notes on behaviour
// - Carry sets on add carry-out or subtract no-borrow; rotate through carry updates it.
// - Half carry sets on low-nibble carry in add or no nibble borrow in subtract.
// - Zero flag sets when an arithmetic or logic result is zero.
// - Wrap flag sets when carry into top bit differs from carry out.
// - Bus writes to status never change power-down or watchdog-expired flags.
// - Power-down flag clears on reset or watchdog clear, sets on power-down instruction.
// - Watchdog-expired clears on reset, watchdog clear or power-down; sets on time-out.
// - Only the program counter is pushed on entry or call, never status.
// - Primary control bits 0..3: global, pin, timer 0, timer 1 enables.
// - Primary control bits 4..6: pin, timer 0, timer 1 pending; bit 7 reads 0.
// - Secondary control: conversion enable bit 0, pending bit 4, others read 0.
// - A falling edge on the external pin sets its pending flag.
// - Timer overflows set their own pending flags.
// - Conversion done sets the conversion pending flag.
// - Enabled pending source with global enable and room calls its vector.
// - Acknowledge clears that pending flag and the global enable.
// - Full stack withholds acknowledge, flag kept, until a return pops.
// - Flags latch while global enable is off; software may re-enable to nest.
// - Interrupt exit sets global enable; subroutine exit leaves it.
// - Requests are sampled and serviced on the phase-two strobe.
// - Priority: pin, timer 0, timer 1, conversion.
// - Pending flags hold until serviced or cleared by software.
// - Every source can wake the device from power-down.
// - A source already pending at power-down entry cannot wake.
// - Six-level return stack whose fullness gates acknowledge.
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "msi_defines.svh"
module msi_unit #(
    parameter int PC_W = `MSI_PC_W,
    parameter int STACK_DEPTH = `MSI_STACK_DEPTH
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core sequencer
    input wire logic phase_two_clock,
    input wire logic [PC_W-1:0] core_pc,
    input wire logic call_push,
    input wire logic isr_exit,
    input wire logic subroutine_exit,
    input wire logic halt_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_timeout,
    // Arithmetic operations
    input wire logic alu_go,
    input wire msi_pkg::msi_alu_op_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    output logic [7:0] alu_result,
    output logic [7:0] status_flags,
    // Request sources
    input wire logic ext_irq_n,
    input wire logic timer0_ovf,
    input wire logic timer1_ovf,
    input wire logic conv_done,
    // Interrupt and stack answers
    output logic irq_take,
    output logic [PC_W-1:0] irq_vector,
    output logic [PC_W-1:0] ret_pc,
    output logic ret_pc_valid,
    output logic stack_full,
    output logic wake
);

    localparam int SP_W = $clog2(STACK_DEPTH);
    localparam int CNT_W = $clog2(STACK_DEPTH + 1);

    generate
        if (PC_W < 5 || STACK_DEPTH < 2 || STACK_DEPTH > 64) begin : g_bad_param
            $error("msi_unit: PC_W must be at least 5 and STACK_DEPTH 2 to 64");
        end
    endgenerate

    // Wrapping pointer steps over a non power-of-two depth
    function automatic logic [SP_W-1:0] ptr_inc(input logic [SP_W-1:0] p);
        ptr_inc = (p == SP_W'(STACK_DEPTH - 1)) ? '0 : p + SP_W'(1);
    endfunction

    function automatic logic [SP_W-1:0] ptr_dec(input logic [SP_W-1:0] p);
        ptr_dec = (p == '0) ? SP_W'(STACK_DEPTH - 1) : p - SP_W'(1);
    endfunction

    // Registers
    logic c_r, ac_r, z_r, ov_r, pdf_r, to_r;
    logic gie_r, ext_en_r, t0_en_r, t1_en_r, conv_en_r;
    logic ext_p_r, t0_p_r, t1_p_r, conv_p_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [7:0] alu_result_r;
    logic irq_take_r, ret_pc_valid_r, wake_r;
    logic [PC_W-1:0] irq_vector_r;
    logic ext_s1_r, ext_s2_r, ext_s3_r;
    logic [SP_W-1:0] top_r;
    logic [CNT_W-1:0] count_r;
    logic full_r;
    logic [3:0] wake_arm_r;
    msi_pkg::msi_pwr_t pwr_r;
    msi_pkg::msi_pwr_t pwr_nxt;

    // APB decode
    wire [9:0] word_idx = paddr[11:2];
    wire hit_status = (word_idx == `MSI_IDX_STATUS);
    wire hit_ctrl0 = (word_idx == `MSI_IDX_CTRL0);
    wire hit_ctrl1 = (word_idx == `MSI_IDX_CTRL1);
    wire hit_any = hit_status | hit_ctrl0 | hit_ctrl1;
    wire setup_ph = psel & ~penable;
    wire wr_done = psel & penable & pready_r & pwrite;
    wire wr_status = wr_done & hit_status;
    wire wr_ctrl0 = wr_done & hit_ctrl0;
    wire wr_ctrl1 = wr_done & hit_ctrl1;

    // Register images; unused bits read as zero
    wire [7:0] status_img = {2'b00, to_r, pdf_r, ov_r, z_r, ac_r, c_r};
    wire [7:0] ctrl0_img = {1'b0, t1_p_r, t0_p_r, ext_p_r, t1_en_r, t0_en_r, ext_en_r, gie_r};
    wire [7:0] ctrl1_img = {3'b000, conv_p_r, 3'b000, conv_en_r};
    wire [7:0] rd_byte = hit_status ? status_img :
                         hit_ctrl0 ? ctrl0_img :
                         hit_ctrl1 ? ctrl1_img : `MSI_REG_RST;

    // Arithmetic flag generation, subtraction as add of inverted operand
    wire is_sub = (alu_op == msi_pkg::MSI_ALU_SUB) | (alu_op == msi_pkg::MSI_ALU_SBC);
    wire is_arith = (alu_op == msi_pkg::MSI_ALU_ADD) | (alu_op == msi_pkg::MSI_ALU_ADC) | is_sub;
    wire is_logic = (alu_op == msi_pkg::MSI_ALU_AND) | (alu_op == msi_pkg::MSI_ALU_OR) |
                    (alu_op == msi_pkg::MSI_ALU_XOR);
    wire [7:0] opnd_b = is_sub ? ~alu_b : alu_b;
    wire cin = (alu_op == msi_pkg::MSI_ALU_ADC || alu_op == msi_pkg::MSI_ALU_SBC) ? c_r :
               (alu_op == msi_pkg::MSI_ALU_SUB);
    wire [8:0] sum9 = {1'b0, alu_a} + {1'b0, opnd_b} + {8'h00, cin};
    wire [4:0] sum_lo = {1'b0, alu_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
    wire [7:0] sum_7 = {1'b0, alu_a[6:0]} + {1'b0, opnd_b[6:0]} + {7'h00, cin};
    wire [7:0] logic_res = (alu_op == msi_pkg::MSI_ALU_AND) ? (alu_a & alu_b) :
                           (alu_op == msi_pkg::MSI_ALU_OR) ? (alu_a | alu_b) : (alu_a ^ alu_b);
    wire [7:0] rot_res = {alu_a[6:0], c_r};
    wire [7:0] alu_res = is_arith ? sum9[7:0] : (is_logic ? logic_res : rot_res);
    wire alu_c = is_arith ? sum9[8] : alu_a[7];
    wire alu_ac = sum_lo[4];
    wire alu_z = (alu_res == 8'h00);
    wire alu_ov = sum_7[7] ^ sum9[8];
    wire upd_c = alu_go & ~is_logic;
    wire upd_arith = alu_go & is_arith;
    wire upd_z = alu_go & (is_arith | is_logic);

    // External pin: two-stage synchroniser, then falling edge
    wire ext_fall = ext_s3_r & ~ext_s2_r;

    // Request selection and acknowledge
    wire [3:0] set_vec = {conv_done, timer1_ovf, timer0_ovf, ext_fall};
    wire [3:0] pend_vec = {conv_p_r, t1_p_r, t0_p_r, ext_p_r};
    wire [3:0] en_vec = {conv_en_r, t1_en_r, t0_en_r, ext_en_r};
    wire [3:0] req_vec = pend_vec & en_vec;
    wire full = full_r;
    wire core_stack_op = call_push | isr_exit | subroutine_exit;
    // Acknowledge waits for a strobe, room and a quiet stack port
    wire take = phase_two_clock & gie_r & ~full & ~core_stack_op & (|req_vec);
    wire [3:0] grant = req_vec & ~{req_vec[2:0] | {req_vec[1:0], 1'b0} | {req_vec[0], 2'b00}, 1'b0};
    wire [3:0] ack_vec = take ? grant : 4'h0;
    wire [11:0] vec_sel = grant[0] ? `MSI_VEC_EXT :
                          grant[1] ? `MSI_VEC_T0 :
                          grant[2] ? `MSI_VEC_T1 : `MSI_VEC_CONV;

    // Pending next: hardware set wins over software clear and acknowledge
    wire [3:0] sw_wr = {wr_ctrl1, wr_ctrl0, wr_ctrl0, wr_ctrl0};
    wire [3:0] sw_val = {pwdata[`MSI_C1_CONV_P], pwdata[`MSI_C0_T1_P], pwdata[`MSI_C0_T0_P], pwdata[`MSI_C0_EXT_P]};
    wire [3:0] pend_nxt = set_vec | (sw_wr & sw_val) | (~sw_wr & pend_vec & ~ack_vec);

    // Stack pointer movement; the core never pushes and pops together
    wire push = call_push | take;
    wire pop = isr_exit | subroutine_exit;
    wire [SP_W-1:0] rd_ptr = ptr_dec(top_r);
    // Count saturates both ways; full kept in a flop so the port is registered
    wire [CNT_W-1:0] count_nxt = push ? (full ? count_r : count_r + CNT_W'(1)) :
                                 pop ? ((count_r == '0) ? count_r : count_r - CNT_W'(1)) : count_r;

    msi_stack_mem #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH),
        .AW(SP_W)
    ) u_stack (
        .clk_sys(clk_sys),
        .we(push),
        .waddr(top_r),
        .wdata(core_pc),
        .raddr(rd_ptr),
        .rdata(ret_pc)
    );

    // Wake while powered down once a freshly armed flag rises
    wire wake_hit = |(pend_vec & wake_arm_r);

    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            msi_pkg::MSI_PWR_RUN: begin
                if (halt_exec) begin
                    pwr_nxt = msi_pkg::MSI_PWR_DOWN;
                end
            end
            msi_pkg::MSI_PWR_DOWN: begin
                if (wake_hit || watchdog_timeout) begin
                    pwr_nxt = msi_pkg::MSI_PWR_RUN;
                end
            end
        endcase
    end

    // APB slave: one wait-free access phase
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph & ~hit_any;
            if (setup_ph) begin
                prdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Arithmetic flags; an operation outranks a bus write in the same cycle
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            c_r <= 1'b0;
            ac_r <= 1'b0;
            z_r <= 1'b0;
            ov_r <= 1'b0;
            alu_result_r <= 8'h00;
        end else begin
            c_r <= upd_c ? alu_c : (wr_status ? pwdata[`MSI_ST_CARRY] : c_r);
            ac_r <= upd_arith ? alu_ac : (wr_status ? pwdata[`MSI_ST_HALF] : ac_r);
            z_r <= upd_z ? alu_z : (wr_status ? pwdata[`MSI_ST_ZERO] : z_r);
            ov_r <= upd_arith ? alu_ov : (wr_status ? pwdata[`MSI_ST_WRAP] : ov_r);
            if (alu_go) begin
                alu_result_r <= alu_res;
            end
        end
    end

    // Reset-cause flags, untouched by bus writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pdf_r <= 1'b0;
            to_r <= 1'b0;
        end else begin
            pdf_r <= halt_exec | (pdf_r & ~watchdog_clear_instruction);
            to_r <= watchdog_timeout | (to_r & ~watchdog_clear_instruction & ~halt_exec);
        end
    end

    // Enables; acknowledge drops the global enable first
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gie_r <= 1'b0;
            ext_en_r <= 1'b0;
            t0_en_r <= 1'b0;
            t1_en_r <= 1'b0;
            conv_en_r <= 1'b0;
        end else begin
            if (take) begin
                gie_r <= 1'b0;
            end else if (isr_exit) begin
                gie_r <= 1'b1;
            end else if (wr_ctrl0) begin
                gie_r <= pwdata[`MSI_C0_GIE];
            end
            if (wr_ctrl0) begin
                ext_en_r <= pwdata[`MSI_C0_EXT_EN];
                t0_en_r <= pwdata[`MSI_C0_T0_EN];
                t1_en_r <= pwdata[`MSI_C0_T1_EN];
            end
            if (wr_ctrl1) begin
                conv_en_r <= pwdata[`MSI_C1_CONV_EN];
            end
        end
    end

    // Pending flags and pin synchroniser
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_p_r <= 1'b0;
            t0_p_r <= 1'b0;
            t1_p_r <= 1'b0;
            conv_p_r <= 1'b0;
            ext_s1_r <= `MSI_PIN_IDLE;
            ext_s2_r <= `MSI_PIN_IDLE;
            ext_s3_r <= `MSI_PIN_IDLE;
        end else begin
            ext_p_r <= pend_nxt[0];
            t0_p_r <= pend_nxt[1];
            t1_p_r <= pend_nxt[2];
            conv_p_r <= pend_nxt[3];
            ext_s1_r <= ext_irq_n;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // Stack pointer and call answers; a push on a full stack overwrites the oldest entry
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            top_r <= '0;
            count_r <= '0;
            full_r <= 1'b0;
            irq_take_r <= 1'b0;
            irq_vector_r <= '0;
            ret_pc_valid_r <= 1'b0;
        end else begin
            if (push) begin
                top_r <= ptr_inc(top_r);
            end else if (pop) begin
                top_r <= rd_ptr;
            end
            count_r <= count_nxt;
            full_r <= (count_nxt == CNT_W'(STACK_DEPTH));
            irq_take_r <= take;
            if (take) begin
                irq_vector_r <= PC_W'(vec_sel);
            end
            ret_pc_valid_r <= pop;
        end
    end

    // Power-down tracking and wake pulse
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pwr_r <= msi_pkg::MSI_PWR_RUN;
            wake_arm_r <= 4'h0;
            wake_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            if (pwr_r == msi_pkg::MSI_PWR_RUN && halt_exec) begin
                wake_arm_r <= ~pend_vec;
            end
            wake_r <= (pwr_r == msi_pkg::MSI_PWR_DOWN) & wake_hit;
        end
    end

    // Outputs
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign alu_result = alu_result_r;
    assign status_flags = status_img;
    assign irq_take = irq_take_r;
    assign irq_vector = irq_vector_r;
    assign ret_pc_valid = ret_pc_valid_r;
    assign stack_full = full;
    assign wake = wake_r;

endmodule

// *** tb/msi_unit_sva.sv ***
// Port checker for the status and interrupt unit
`timescale 1ns/100ps
`include "msi_defines.svh"
module msi_unit_sva #(
    parameter int PC_W = 12
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    // Core sequencer
    input wire logic phase_two_clock,
    input wire logic isr_exit,
    input wire logic halt_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_timeout,
    input wire logic alu_go,
    input wire msi_pkg::msi_alu_op_t alu_op,
    // Answers
    input wire logic [7:0] alu_result,
    input wire logic [7:0] status_flags,
    input wire logic irq_take,
    input wire logic [PC_W-1:0] irq_vector,
    input wire logic stack_full
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_take_strobe: assert property (irq_take |-> $past(phase_two_clock))
        else $error("acknowledge without phase-two strobe");
    a_take_single: assert property (irq_take && !psel && !isr_exit ##1 (!psel && !isr_exit) [*3]
        |=> !irq_take) else $error("second acknowledge with global enable cleared");
    a_take_room: assert property (irq_take |-> !$past(stack_full))
        else $error("acknowledge while stack full");
    a_vector_known: assert property (irq_take |-> irq_vector inside {`MSI_VEC_EXT, `MSI_VEC_T0,
        `MSI_VEC_T1, `MSI_VEC_CONV}) else $error("unknown entry vector");
    a_write_keeps: assert property (psel && penable && pready && pwrite && paddr[11:2] == `MSI_IDX_STATUS
        && !halt_exec && !watchdog_clear_instruction && !watchdog_timeout |=> $stable(status_flags[5:4]))
        else $error("status write moved protected flags");
    a_down_flags: assert property (halt_exec && !watchdog_timeout |=> status_flags[5:4] == 2'b01)
        else $error("power-down flags wrong after halt");
    a_clear_flags: assert property (watchdog_clear_instruction && !halt_exec && !watchdog_timeout
        |=> status_flags[5:4] == 2'b00) else $error("flags not cleared by watchdog clear");
    a_timeout_sets: assert property (watchdog_timeout |=> status_flags[5])
        else $error("expired flag not set");
    a_zero_flag: assert property (alu_go && alu_op != msi_pkg::MSI_ALU_RLC
        |=> status_flags[2] == (alu_result == 8'h00)) else $error("zero flag disagrees with result");

    c_take_conv: cover property (irq_take && irq_vector == `MSI_VEC_CONV);
    c_full_strobe: cover property (stack_full && phase_two_clock);
    c_down: cover property (halt_exec ##1 status_flags[4]);
endmodule

bind msi_unit msi_unit_sva #(.PC_W(PC_W)) u_sva (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pready,
    .phase_two_clock, .isr_exit, .halt_exec, .watchdog_clear_instruction, .watchdog_timeout, .alu_go, .alu_op,
    .alu_result, .status_flags, .irq_take, .irq_vector, .stack_full);

// *** tb/msi_core_model.sv ***
// Core sequencer stand-in: phase-two strobe and program counter
`timescale 1ns/100ps
module msi_core_model #(
    parameter int PC_W = 12,
    parameter logic [PC_W-1:0] START_PC = 12'h123
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Unit answers
    input wire logic irq_take,
    input wire logic [PC_W-1:0] irq_vector,
    // Core outputs
    output logic phase_two_clock,
    output logic [PC_W-1:0] core_pc
);
    logic [1:0] phase_r;

    // One strobe per four-clock machine cycle
    assign phase_two_clock = (phase_r == 2'h1);

    // Pc moves only on entry, so every pushed value is known
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_r <= 2'h0;
            core_pc <= START_PC;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (irq_take) begin
                core_pc <= irq_vector;
            end
        end
    end
endmodule

// *** tb/msi_unit_bench.sv ***
// Self-checking bench for the status and interrupt unit
`timescale 1ns/100ps
`include "msi_defines.svh"
module msi_unit_bench;
    localparam logic [11:0] A_ST = {`MSI_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_C0 = {`MSI_IDX_CTRL0, 2'b00};
    localparam logic [11:0] A_C1 = {`MSI_IDX_CTRL1, 2'b00};
    localparam logic [8:0] CALL = 9'h001, IEXIT = 9'h002, SEXIT = 9'h004, DOWN = 9'h008, WCLR = 9'h010;
    localparam logic [8:0] WTO = 9'h020, TM0 = 9'h040, TM1 = 9'h080, CONV = 9'h100;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err;
    logic [8:0] ev = 9'h000;
    logic ext_irq_n = 1'b1, alu_go = 1'b0;
    msi_pkg::msi_alu_op_t alu_op = msi_pkg::MSI_ALU_ADD;
    logic [7:0] alu_a = 8'h00, alu_b = 8'h00, alu_result, status_flags;
    logic [11:0] core_pc, irq_vector, ret_pc;
    logic phase_two_clock, irq_take, ret_pc_valid, stack_full, wake;
    int fail_count = 0, samples_checked = 0, cycles = 0, wakes = 0;

    msi_unit DUT (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .phase_two_clock, .core_pc, .call_push(ev[0]), .isr_exit(ev[1]), .subroutine_exit(ev[2]),
        .halt_exec(ev[3]), .watchdog_clear_instruction(ev[4]), .watchdog_timeout(ev[5]), .alu_go, .alu_op,
        .alu_a, .alu_b, .alu_result, .status_flags, .ext_irq_n, .timer0_ovf(ev[6]), .timer1_ovf(ev[7]),
        .conv_done(ev[8]), .irq_take, .irq_vector, .ret_pc, .ret_pc_valid, .stack_full, .wake);
    msi_core_model core (.clk_sys, .nrst, .irq_take, .irq_vector, .phase_two_clock, .core_pc);

    always #5 clk_sys = ~clk_sys;

    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Run ceiling; whole sequence needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (wake === 1'b1) begin
            wakes <= wakes + 1;
        end
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask

    task automatic strobe(input logic [8:0] b);
        @(posedge clk_sys);
        ev <= b;
        @(posedge clk_sys);
        ev <= 9'h000;
    endtask

    task automatic flags(input logic [7:0] e);
        @(posedge clk_sys);
        chk({24'h0, status_flags}, {24'h0, e});
    endtask

    task automatic alu(input msi_pkg::msi_alu_op_t op, input logic [7:0] a, b, r, f);
        @(posedge clk_sys);
        alu_go <= 1'b1;
        alu_op <= op;
        alu_a <= a;
        alu_b <= b;
        @(posedge clk_sys);
        alu_go <= 1'b0;
        flags(f);
        chk({24'h0, alu_result}, {24'h0, r});
    endtask

    task automatic take(input logic [11:0] v);
        while (irq_take !== 1'b1) begin
            @(posedge clk_sys);
        end
        chk({20'h0, irq_vector}, {20'h0, v});
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(A_ST, 8'h00);
        rd(A_C0, 8'h00);
        rd(A_C1, 8'h00);
        apb(1'b0, 12'h000, 8'h00);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, A_C0, 8'h80);
        rd(A_C0, 8'h00);
        apb(1'b1, A_C1, 8'hEE);
        rd(A_C1, 8'h00);
        alu(msi_pkg::MSI_ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'h0A);
        alu(msi_pkg::MSI_ALU_AND, 8'hF0, 8'h0F, 8'h00, 8'h0E);
        alu(msi_pkg::MSI_ALU_ADC, 8'h01, 8'h01, 8'h02, 8'h00);
        alu(msi_pkg::MSI_ALU_SUB, 8'h10, 8'h10, 8'h00, 8'h07);
        alu(msi_pkg::MSI_ALU_SBC, 8'h05, 8'h02, 8'h03, 8'h03);
        alu(msi_pkg::MSI_ALU_RLC, 8'h01, 8'h00, 8'h03, 8'h02);
        alu(msi_pkg::MSI_ALU_OR, 8'h00, 8'h00, 8'h00, 8'h06);
        alu(msi_pkg::MSI_ALU_XOR, 8'h55, 8'hAA, 8'hFF, 8'h02);
        apb(1'b1, A_ST, 8'hFF);
        rd(A_ST, 8'h0F);
        strobe(DOWN);
        flags(8'h1F);
        strobe(WTO);
        flags(8'h3F);
        apb(1'b1, A_ST, 8'h00);
        rd(A_ST, 8'h30);
        strobe(DOWN);
        flags(8'h10);
        strobe(TM1);
        repeat (8) @(posedge clk_sys);
        chk(wakes, 32'h1);
        strobe(WCLR);
        flags(8'h00);
        strobe(DOWN);
        strobe(TM1);
        repeat (8) @(posedge clk_sys);
        chk(wakes, 32'h1);
        strobe(WTO);
        apb(1'b1, A_C0, 8'h00);
        rd(A_C0, 8'h00);
        apb(1'b1, A_C0, 8'h8E);
        rd(A_C0, 8'h0E);
        apb(1'b1, A_C1, 8'hE1);
        rd(A_C1, 8'h01);
        @(posedge clk_sys);
        ext_irq_n <= 1'b0;
        ev <= TM0 | TM1 | CONV;
        @(posedge clk_sys);
        ev <= 9'h000;
        repeat (4) @(posedge clk_sys);
        rd(A_C0, 8'h7E);
        rd(A_C1, 8'h11);
        apb(1'b1, A_C0, 8'h7F);
        take(`MSI_VEC_EXT);
        rd(A_C0, 8'h6E);
        strobe(IEXIT);
        @(posedge clk_sys);
        chk({31'h0, ret_pc_valid}, 32'h1);
        chk({20'h0, ret_pc}, 32'h123);
        take(`MSI_VEC_T0);
        strobe(SEXIT);
        rd(A_C0, 8'h4E);
        apb(1'b1, A_C0, 8'h4F);
        take(`MSI_VEC_T1);
        rd(A_C0, 8'h0E);
        apb(1'b1, A_C0, 8'h0F);
        take(`MSI_VEC_CONV);
        rd(A_C1, 8'h01);
        repeat (4) strobe(CALL);
        @(posedge clk_sys);
        chk({31'h0, stack_full}, 32'h1);
        strobe(TM0);
        apb(1'b1, A_C0, 8'h2F);
        repeat (12) @(posedge clk_sys);
        rd(A_C0, 8'h2F);
        strobe(SEXIT);
        take(`MSI_VEC_T0);
        // Mid-run reset with a full stack and both cause flags set
        nrst <= 1'b0;
        ext_irq_n <= 1'b1;
        @(posedge clk_sys);
        nrst <= 1'b1;
        rd(A_C0, 8'h00);
        rd(A_ST, 8'h00);
        chk({31'h0, stack_full}, 32'h0);
        conclude();
    end
endmodule
